// ### src/pepc_pkg.sv
// package of constants for the parallel eeprom page write host controller
package pepc_pkg;
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned ADDR_W           = 15;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned PAGE_BYTES       = 64;
  localparam int unsigned OFS_W            = 6;
  // strobe timing, in ns, and derived clock counts (least times round up)
  localparam int unsigned T_SETUP_NS       = 50;
  localparam int unsigned T_PULSE_NS       = 150;
  localparam int unsigned T_HOLD_NS        = 100;
  localparam int unsigned T_ACC_NS         = 250;
  localparam int unsigned T_SETUP_CYC      = (T_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned T_PULSE_CYC      = (T_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned T_HOLD_CYC       = (T_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned T_ACC_CYC        = (T_ACC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // byte load window, longest time rounds down
  localparam int unsigned T_BLC_US         = 200;
  localparam int unsigned T_BLC_CYC        = T_BLC_US * (CLK_HZ / 1_000_000);
  // write cycle time limit for polling, in ms
  localparam int unsigned T_WC_MS          = 10;
  localparam int unsigned T_WC_CYC         = T_WC_MS * (CLK_HZ / 1000);
  // command sequence words
  localparam logic [14:0] CMD_ADDR_A       = 15'h5555;
  localparam logic [14:0] CMD_ADDR_B       = 15'h2AAA;
  localparam logic [7:0]  CMD_DAT_AA       = 8'hAA;
  localparam logic [7:0]  CMD_DAT_55       = 8'h55;
  localparam logic [7:0]  CMD_DAT_A0       = 8'hA0;
  localparam logic [7:0]  CMD_DAT_80       = 8'h80;
  localparam logic [7:0]  CMD_DAT_20       = 8'h20;
  localparam logic [2:0]  CMD_LEN_MAX      = 3'h6;
  typedef enum logic [6:0] {
    PEPC_IDLE  = 7'b0000001,
    PEPC_SETUP = 7'b0000010,
    PEPC_PULSE = 7'b0000100,
    PEPC_HOLD  = 7'b0001000,
    PEPC_RSET  = 7'b0010000,
    PEPC_RACC  = 7'b0100000,
    PEPC_POLL  = 7'b1000000
  } pepc_state_t;
endpackage

// ### src/pepc_page_mem.sv
// page staging memory: 64 bytes with presence bits, registered read data
module pepc_page_mem
  import pepc_pkg::*;
#(
  parameter int unsigned DEPTH = PAGE_BYTES
) (
  input  wire logic                     clock_i,
  input  wire logic                     resetn_i,
  input  wire logic                     wr_en_i,
  input  wire logic [OFS_W-1:0]         wr_ofs_i,
  input  wire logic [DATA_W-1:0]        wr_data_i,
  input  wire logic                     clr_i,
  input  wire logic [OFS_W-1:0]         rd_ofs_i,
  output logic      [DATA_W-1:0]        rd_data_o,
  output logic                          rd_valid_o
);
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0]  have_q;

  initial begin
    if (DEPTH != (1 << OFS_W)) $error("page depth must match offset width");
  end

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_q[wr_ofs_i] <= wr_data_i;
    end
  end

  // a reload simply overwrites the slot
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      have_q <= '0;
    end else begin
      // a slot staged in the clearing cycle survives: set wins over clear
      if (clr_i) have_q <= '0;
      if (wr_en_i) have_q[wr_ofs_i] <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_data_o  <= mem_q[rd_ofs_i];
      rd_valid_o <= have_q[rd_ofs_i];
    end
  end
endmodule

// ### src/pepc_host.sv
// host controller driving the parallel eeprom pins: reads, page writes, polling
// Summary of operation
// - read only while select and gate low
// - write: select and strobe low, gate high
// - next byte within 200 us of previous
// - true data ends busy, next cycle allowed
// - protected mode: unlock before every page; host sends it only when protect_i is set
// - unlock starts AA@5555, 55@2AAA
// - third unlock word A0@5555, then data
// - disable uses six-word sequence
module pepc_host
  import pepc_pkg::*;
#(
  parameter int unsigned BLC_CYC = T_BLC_CYC,
  parameter int unsigned WC_CYC  = T_WC_CYC
) (
  input  wire logic                clock_i,
  input  wire logic                resetn_i,
  // user side
  input  wire logic                stage_i,
  input  wire logic [OFS_W-1:0]    stage_ofs_i,
  input  wire logic [DATA_W-1:0]   stage_data_i,
  input  wire logic                page_go_i,
  input  wire logic [8:0]          page_num_i,
  input  wire logic                protect_i,
  input  wire logic                unprotect_i,
  input  wire logic                rd_req_i,
  input  wire logic [ADDR_W-1:0]   rd_addr_i,
  output logic                     ready_o,
  output logic                     rd_done_o,
  output logic     [DATA_W-1:0]    rd_data_o,
  output logic                     wr_done_o,
  output logic                     wr_err_o,
  // device pins
  output logic     [ADDR_W-1:0]    addr_lines_o,
  output logic     [DATA_W-1:0]    data_pins_o,
  output logic                     data_pins_oe_o,
  input  wire logic [DATA_W-1:0]   data_pins_i,
  output logic                     csn_o,
  output logic                     oen_o,
  output logic                     wen_o
);
  initial begin
    // the slot walk spends two cycles per empty slot between strobes
    if (BLC_CYC < 2 * PAGE_BYTES + 2 * (T_SETUP_CYC + T_PULSE_CYC + T_HOLD_CYC + 3))
      $error("load window too short");
    if (BLC_CYC > 32'h00FFFFFF) $error("load window too long");
    if (WC_CYC < 1 || WC_CYC > 32'h00FFFFFF) $error("write cycle count out of range");
  end

  // ==========================================================================
  // state
  // ==========================================================================
  pepc_state_t state_q;
  logic [23:0] tmr_q;
  logic [23:0] gap_q;
  logic [23:0] wc_q;
  logic [7:0]  scan_q;
  logic [2:0]  cmd_q;
  logic [2:0]  cmd_len_q;
  logic        writing_q;
  logic        polling_q;
  logic [8:0]  page_q;
  logic [5:0]  last_ofs_q;
  logic [7:0]  last_dat_q;
  logic [7:0]  cur_dat_q;
  logic [14:0] cur_adr_q;
  logic        byte_ok;
  logic [7:0]  mem_rd;
  logic        mem_vld;
  logic        tmr_done;
  logic        wc_done;
  logic        issue;
  logic [14:0] cmd_adr;
  logic [7:0]  cmd_dat;

  assign tmr_done = (tmr_q == 24'h000000);
  assign wc_done  = (wc_q == 24'h000000);
  assign ready_o  = (state_q == PEPC_IDLE) && !writing_q;

  pepc_page_mem u_mem (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .wr_en_i    (stage_i && ready_o),
    .wr_ofs_i   (stage_ofs_i),
    .wr_data_i  (stage_data_i),
    .clr_i      (wr_done_o),
    .rd_ofs_i   (scan_q[5:0]),
    .rd_data_o  (mem_rd),
    .rd_valid_o (mem_vld)
  );

  // command word per step; the third word decides enable or disable
  always_comb begin
    cmd_adr = CMD_ADDR_A;
    cmd_dat = CMD_DAT_AA;
    unique case (cmd_q)
      3'h0: begin cmd_adr = CMD_ADDR_A; cmd_dat = CMD_DAT_AA; end
      3'h1: begin cmd_adr = CMD_ADDR_B; cmd_dat = CMD_DAT_55; end
      3'h2: begin
        cmd_adr = CMD_ADDR_A;
        cmd_dat = (cmd_len_q == CMD_LEN_MAX) ? CMD_DAT_80 : CMD_DAT_A0;
      end
      3'h3: begin cmd_adr = CMD_ADDR_A; cmd_dat = CMD_DAT_AA; end
      3'h4: begin cmd_adr = CMD_ADDR_B; cmd_dat = CMD_DAT_55; end
      default: begin cmd_adr = CMD_ADDR_A; cmd_dat = CMD_DAT_20; end
    endcase
  end

  // a byte is sent once its registered presence bit has been read back
  assign byte_ok = (cmd_q >= cmd_len_q) && mem_vld && scan_q[6];

  // ==========================================================================
  // main sequencer
  // ==========================================================================
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q   <= PEPC_IDLE;
      tmr_q     <= 24'h000000;
      writing_q <= 1'b0;
      polling_q <= 1'b0;
    end else begin
      if (!tmr_done) tmr_q <= tmr_q - 24'h000001;
      unique case (state_q)
        PEPC_IDLE: begin
          if (writing_q && issue) begin
            state_q <= PEPC_SETUP;
            tmr_q   <= 24'(T_SETUP_CYC);
          end else if (!writing_q && page_go_i) begin
            writing_q <= 1'b1;
          end else if (!writing_q && rd_req_i) begin
            state_q <= PEPC_RSET;
            tmr_q   <= 24'(T_ACC_CYC);
          end else if (writing_q && scan_q[7] && cmd_q >= cmd_len_q) begin
            state_q   <= PEPC_POLL;
            polling_q <= 1'b1;
          end
        end
        PEPC_SETUP: if (tmr_done) begin
          state_q <= PEPC_PULSE;
          tmr_q   <= 24'(T_PULSE_CYC);
        end
        PEPC_PULSE: if (tmr_done) begin
          state_q <= PEPC_HOLD;
          tmr_q   <= 24'(T_HOLD_CYC);
        end
        PEPC_HOLD: if (tmr_done) state_q <= PEPC_IDLE;
        PEPC_RSET: if (tmr_done) state_q <= polling_q ? PEPC_POLL : PEPC_RACC;
        PEPC_RACC: state_q <= PEPC_IDLE;
        PEPC_POLL: begin
          if (data_pins_i == last_dat_q || wc_done) begin
            state_q   <= PEPC_IDLE;
            writing_q <= 1'b0;
            polling_q <= 1'b0;
          end else begin
            state_q <= PEPC_RSET;
            tmr_q   <= 24'(T_ACC_CYC);
          end
        end
        default: state_q <= PEPC_IDLE;
      endcase
    end
  end

  // issue the next strobe: command word, else next staged byte
  assign issue = (cmd_q < cmd_len_q) || byte_ok;

  // ==========================================================================
  // page walk and command progress
  // ==========================================================================
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scan_q     <= 8'h00;
      cmd_q      <= 3'h0;
      cmd_len_q  <= 3'h0;
      page_q     <= 9'h000;
      last_ofs_q <= 6'h00;
      last_dat_q <= 8'h00;
      cur_dat_q  <= 8'h00;
      cur_adr_q  <= 15'h0000;
    end else if (state_q == PEPC_IDLE && !writing_q && page_go_i) begin
      page_q    <= page_num_i;
      scan_q    <= 8'h00;
      cmd_q     <= 3'h0;
      cmd_len_q <= unprotect_i ? CMD_LEN_MAX : (protect_i ? 3'h3 : 3'h0);
    end else if (state_q == PEPC_IDLE && writing_q && issue) begin
      if (cmd_q < cmd_len_q) begin
        cur_adr_q <= cmd_adr;
        cur_dat_q <= cmd_dat;
        cmd_q     <= cmd_q + 3'h1;
      end else begin
        cur_adr_q  <= {page_q, scan_q[5:0]};
        cur_dat_q  <= mem_rd;
        last_ofs_q <= scan_q[5:0];
        last_dat_q <= mem_rd;
        scan_q     <= (scan_q[5:0] == 6'h3F) ? 8'h80 : {2'b00, scan_q[5:0] + 6'h01};
      end
    end else if (state_q == PEPC_IDLE && writing_q && cmd_q >= cmd_len_q && !scan_q[7]) begin
      // skip absent slots; bit 6 marks a fresh readback, bit 7 the end of the walk
      if (!scan_q[6]) begin
        scan_q <= {2'b01, scan_q[5:0]};
      end else begin
        scan_q <= (scan_q[5:0] == 6'h3F) ? 8'h80 : {2'b00, scan_q[5:0] + 6'h01};
      end
    end
  end

  // gap since last strobe; the walk can wait two cycles per empty slot
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_q <= 24'h000000;
    end else if (state_q == PEPC_HOLD || !writing_q) begin
      gap_q <= 24'h000000;
    end else if (gap_q != 24'hFFFFFF) begin
      gap_q <= gap_q + 24'h000001;
    end
  end

  // write cycle limit, apart from the strobe timer that each poll read after the first reuses
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wc_q <= 24'h000000;
    end else if (!polling_q) begin
      wc_q <= 24'(WC_CYC);
    end else if (!wc_done) begin
      wc_q <= wc_q - 24'h000001;
    end
  end

  // ==========================================================================
  // pins and results
  // ==========================================================================
  always_comb begin
    csn_o          = !(state_q inside {PEPC_PULSE, PEPC_RSET, PEPC_RACC, PEPC_POLL});
    wen_o          = (state_q != PEPC_PULSE);
    oen_o          = !(state_q inside {PEPC_RSET, PEPC_RACC, PEPC_POLL});
    data_pins_oe_o = state_q inside {PEPC_SETUP, PEPC_PULSE, PEPC_HOLD};
    addr_lines_o   = polling_q ? {page_q, last_ofs_q} :
                     (state_q inside {PEPC_RSET, PEPC_RACC}) ? rd_addr_i : cur_adr_q;
    data_pins_o    = cur_dat_q;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_done_o <= 1'b0;
      rd_data_o <= 8'h00;
      wr_done_o <= 1'b0;
      wr_err_o  <= 1'b0;
    end else begin
      rd_done_o <= (state_q == PEPC_RACC);
      if (state_q == PEPC_RACC) rd_data_o <= data_pins_i;
      wr_done_o <= (state_q == PEPC_POLL) && (data_pins_i == last_dat_q || wc_done);
      wr_err_o  <= (state_q == PEPC_POLL) && wc_done && (data_pins_i != last_dat_q);
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  a_gate_blocks_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !wen_o |-> (oen_o && !csn_o && data_pins_oe_o))
    else $error("write strobe with gate low or select high");
  a_float_on_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !oen_o |-> !data_pins_oe_o)
    else $error("host drives data during read");
  a_pulse_width: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(wen_o) |-> !wen_o [*3])
    else $error("write pulse too short");
  a_load_window: assert property (@(posedge clock_i) disable iff (!resetn_i)
    writing_q && !polling_q |-> gap_q < 24'(BLC_CYC))
    else $error("byte load window exceeded");
  a_no_strobe_busy: assert property (@(posedge clock_i) disable iff (!resetn_i)
    polling_q |-> wen_o)
    else $error("write strobe during programming");
  a_page_stable: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (writing_q && $past(writing_q)) |-> $stable(page_q))
    else $error("page address changed mid page");
  a_poll_addr: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_q == PEPC_POLL |-> addr_lines_o == {page_q, last_ofs_q})
    else $error("poll read not at last loaded byte");
  a_done_true: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_q == PEPC_POLL && data_pins_i == last_dat_q) |=> wr_done_o && !wr_err_o)
    else $error("completion not reported on true data");
endmodule

// ### tb/pepc_eeprom_model.sv
// behavioural model of the byte-wide eeprom seen by the host controller
module pepc_eeprom_model
  import pepc_pkg::*;
#(
  parameter int unsigned TBLC_NS = 2000,
  parameter int unsigned TWC_NS  = 5000
) (
  input  wire logic [ADDR_W-1:0] addr_lines_i,
  input  wire logic [DATA_W-1:0] data_pins_i,
  input  wire logic              csn_i,
  input  wire logic              oen_i,
  input  wire logic              wen_i,
  output logic      [DATA_W-1:0] data_pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // state
  logic [7:0]  mem [0:32767];
  logic [22:0] ent_q [$];
  logic [22:0] seq_tab [9] = '{{CMD_ADDR_A, CMD_DAT_AA}, {CMD_ADDR_B, CMD_DAT_55},
    {CMD_ADDR_A, CMD_DAT_A0}, {CMD_ADDR_A, CMD_DAT_AA}, {CMD_ADDR_B, CMD_DAT_55},
    {CMD_ADDR_A, CMD_DAT_80}, {CMD_ADDR_A, CMD_DAT_AA}, {CMD_ADDR_B, CMD_DAT_55},
    {CMD_ADDR_A, CMD_DAT_20}};
  logic [14:0] wa;
  logic [14:0] last_a;
  logic [7:0]  last_d;
  logic [7:0]  drv     = 8'h00;
  logic        prot_q  = 1'b0;
  logic        vcc_low = 1'b0;
  logic        pend    = 1'b0;
  logic        prog    = 1'b0;
  int          ld_n    = 0;
  realtime     t_fall;
  event        ld_ev;
  wire wr_act = !csn_i && !wen_i && oen_i && !vcc_low;
  wire rd_act = !csn_i && !oen_i;
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
  function automatic bit has_pre(int base, int n);
    has_pre = (ent_q.size() > n);
    for (int i = 0; i < n; i++)
      if (has_pre && ent_q[i] !== seq_tab[base+i]) has_pre = 1'b0;
  endfunction
  // ==========================================================
  // byte loads
  always @(posedge wr_act) begin
    wa = addr_lines_i;
    t_fall = $realtime;
  end
  always @(negedge wr_act) begin
    if ($realtime - t_fall >= 10.0 && !prog) begin
      ent_q.push_back({wa, data_pins_i});
      last_a = wa;
      last_d = data_pins_i;
      pend = 1'b1;
      ld_n++;
      ->ld_ev;
    end
  end
  // ==========================================================
  // load window closes, then self-timed programming
  initial forever begin
    int k;
    int skip;
    @(ld_ev);
    do begin
      k = ld_n;
      #(TBLC_NS);
    end while (k != ld_n);
    skip = 0;
    if (has_pre(3, 6)) begin
      prot_q = 1'b0;
      skip = 6;
    end else if (has_pre(0, 3)) begin
      prot_q = 1'b1;
      skip = 3;
    end else if (prot_q) begin
      skip = -1;
    end
    if (skip >= 0) begin
      prog = 1'b1;
      #(TWC_NS);
      // page comes from the first data byte; later reloads overwrite earlier ones
      for (int i = skip; i < ent_q.size(); i++)
        mem[{ent_q[skip][22:14], ent_q[i][13:8]}] = ent_q[i][7:0];
    end
    ent_q.delete();
    pend = 1'b0;
    prog = 1'b0;
  end
  // ==========================================================
  // read path: released pins show the inverse of the last value
  always @(rd_act or addr_lines_i or pend) begin
    if (rd_act)
      drv = (pend && addr_lines_i == last_a) ? ~last_d : mem[addr_lines_i];
  end
  assign data_pins_o = rd_act ? drv : ~drv;
endmodule

// ### tb/pepc_host_tb_top.sv
// testbench top: host controller driving the eeprom model
module pepc_host_tb_top
  import pepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, stage, go, prot, unprot, rdreq;
  logic [5:0]  ofs;
  logic [7:0]  sdata;
  logic [8:0]  page;
  logic [14:0] raddr, addr;
  logic ready, rd_done, wr_done, wr_err, hoe, csn, oen, wen;
  logic [7:0]  rd_data, hdq, dev_dq;
  wire  [7:0]  dq_w = hoe ? hdq : dev_dq;
  int error_cnt = 0;
  int num_checks = 0;
  // the load window must outlast a walk over 63 empty slots
  pepc_host #(.BLC_CYC(400), .WC_CYC(2000)) i_dut (.clock_i(clk), .resetn_i(rstn),
    .stage_i(stage), .stage_ofs_i(ofs), .stage_data_i(sdata), .page_go_i(go),
    .page_num_i(page), .protect_i(prot), .unprotect_i(unprot), .rd_req_i(rdreq),
    .rd_addr_i(raddr), .ready_o(ready), .rd_done_o(rd_done), .rd_data_o(rd_data),
    .wr_done_o(wr_done), .wr_err_o(wr_err), .addr_lines_o(addr), .data_pins_o(hdq),
    .data_pins_oe_o(hoe), .data_pins_i(dq_w), .csn_o(csn), .oen_o(oen), .wen_o(wen));
  pepc_eeprom_model #(.TBLC_NS(20000), .TWC_NS(5000)) i_dev (.addr_lines_i(addr),
    .data_pins_i(dq_w), .csn_i(csn), .oen_i(oen), .wen_i(wen), .data_pins_o(dev_dq));
  // ==========================================================
  // helpers
  task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk1(string name, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wait_ready();
    int n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk1("ready", 1'b1, ready);
  endtask
  task automatic stage_byte(logic [5:0] o, logic [7:0] d);
    wait_ready();
    stage = 1'b1;
    ofs = o;
    sdata = d;
    @(negedge clk);
    stage = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(logic [14:0] a, logic [7:0] exp);
    int n = 0;
    wait_ready();
    rdreq = 1'b1;
    raddr = a;
    @(negedge clk);
    rdreq = 1'b0;
    while (rd_done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk1("rd_done", 1'b1, rd_done);
    chk8("rd_data", exp, rd_data);
    @(negedge clk);
  endtask
  task automatic page_wr(logic [8:0] p, logic pr, logic up, logic exp_err);
    int n = 0;
    wait_ready();
    go = 1'b1;
    page = p;
    prot = pr;
    unprot = up;
    @(negedge clk);
    go = 1'b0;
    while (wr_done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk1("wr_done", 1'b1, wr_done);
    chk1("wr_err", exp_err, wr_err);
    @(negedge clk);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic s_idle();
    chk1("csn", 1'b1, csn);
    chk1("wen", 1'b1, wen);
    chk1("data_oe", 1'b0, hoe);
    chk1("ready", 1'b1, ready);
  endtask
  task automatic s_page();
    rd({9'h012, 6'd63}, 8'hFF);
    stage_byte(6'd5, 8'h11);
    stage_byte(6'd1, 8'h22);
    stage_byte(6'd5, 8'h33);
    stage_byte(6'd63, 8'h44);
    page_wr(9'h012, 1'b0, 1'b0, 1'b0);
    rd({9'h012, 6'd5}, 8'h33);
    rd({9'h012, 6'd1}, 8'h22);
    rd({9'h012, 6'd63}, 8'h44);
    rd({9'h012, 6'd2}, 8'hFF);
  endtask
  task automatic s_protect();
    stage_byte(6'd0, 8'h5A);
    page_wr(9'h020, 1'b1, 1'b0, 1'b0);
    chk1("protect_state", 1'b1, i_dev.prot_q);
    rd({9'h020, 6'd0}, 8'h5A);
    stage_byte(6'd1, 8'hC3);
    page_wr(9'h020, 1'b0, 1'b0, 1'b1);
    rd({9'h020, 6'd1}, 8'hFF);
    stage_byte(6'd2, 8'h77);
    page_wr(9'h020, 1'b1, 1'b1, 1'b0);
    chk1("protect_state", 1'b0, i_dev.prot_q);
    rd({9'h020, 6'd2}, 8'h77);
  endtask
  task automatic s_lowvcc();
    i_dev.vcc_low = 1'b1;
    stage_byte(6'd3, 8'h99);
    page_wr(9'h030, 1'b0, 1'b0, 1'b1);
    i_dev.vcc_low = 1'b0;
    rd({9'h030, 6'd3}, 8'hFF);
  endtask
  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rstn, stage, go, prot, unprot, rdreq} = '0;
    ofs = '0;
    sdata = '0;
    page = '0;
    raddr = '0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    s_idle();
    s_page();
    s_protect();
    s_lowvcc();
    stop_test();
  end
  // the scenarios need a few thousand cycles; this leaves ample margin
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
